// >>> verilog/pml_pipe_mac.v
// Behaviour
// - Each of eight lanes drives an 8-bit transmit symbol; lanes 1-7 mirror lane 0.
// - A control flag beside each transmit symbol marks it as a control symbol.
// - Receiver-detect request asks the PHY to detect far end or start loopback.
// - While transmit idle request is high the PHY holds that lane electrically idle.
// - Compliance flag forces negative running disparity in compliance mode.
// - Receive invert tells the PHY to flip polarity into its 8b/10b decoder.
// - Two-bit power-state request selects P0, P0s, P1 or P2.
// - Idle-inference selector: 0xx none, 100 COM/SKP absence, 101 TS absence.
// - Selector 110 idle-exit absence in UI interval, 111 in 128 us window.
// - De-emphasis is chosen by the block from partner training sequences.
// - Export 5-bit training state: detect, polling and early configuration codes.
// - Lane-number, recovery, active and disabled states use their fixed codes.
// - Loopback, standby, L2 wake and speed recovery states use their fixed codes.
// - Two-bit lane rate: 00 first generation, 01 second generation, 1X reserved.
// - Swing select: 0 full swing, 1 half swing.
// - Parallel interface is simulation only, 8-bit or 16-bit single data rate.
// - Three-bit margin code: 000 normal, 001 widest, 010 and 011 reserved.
`include "pml_defs.vh"
`default_nettype none

module pml_pipe_mac #(
    parameter LANES = `PML_LANES
) (
    input wire i_core_clk,
    input wire i_resetn,
    input wire [`PML_ADDR_W-1:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire i_pclk,
    input wire [8*LANES-1:0] i_lane_rx_symbol,
    input wire [2*LANES-1:0] i_lane_rx_ctrl_flag,
    input wire [LANES-1:0] i_lane_rx_locked_valid,
    input wire [LANES-1:0] i_lane_phy_done,
    input wire [3*LANES-1:0] i_lane_rx_status_code,
    input wire [LANES-1:0] i_lane_rx_idle_ind,
    output reg [8*LANES-1:0] o_lane_tx_symbol,
    output reg [LANES-1:0] o_lane_tx_ctrl_flag,
    output reg [LANES-1:0] o_lane_rcvr_detect_req,
    output reg [LANES-1:0] o_lane_tx_idle_req,
    output reg [LANES-1:0] o_lane_neg_disparity_force,
    output reg [LANES-1:0] o_lane_rx_invert,
    output reg [2*LANES-1:0] o_lane_power_state_req,
    output reg [LANES-1:0] o_lane_deemphasis_sel,
    output reg [3*LANES-1:0] o_lane_idle_infer_sel,
    output reg [LANES-1:0] o_lane_swing_sel,
    output reg [3*LANES-1:0] o_lane_tx_margin_code,
    output reg [4:0] o_link_train_state_code,
    output reg [1:0] o_lane_rate_code,
    output reg o_pipe_width16
);

    // Software-held settings, sent to every lane on the next interface clock rise
    // (rate, width, state: each core clock; lsel_q: not sent); invert_q holds one bit per lane
    reg [1:0] pwr_q;
    reg detect_q;
    reg compl_q;
    reg swing_q;
    reg [1:0] rate_q;
    reg [2:0] margin_q;
    reg txidle_q;
    reg width16_q;
    reg [2:0] lsel_q;
    reg [LANES-1:0] invert_q;
    reg [7:0] txsym_q;
    reg txctl_q;
    reg [4:0] state_q;
    reg [2:0] infer_d;

    // Interface clock is sampled; only its rising edge matters
    reg pclk_s1_q;
    reg pclk_s2_q;
    reg pclk_s3_q;
    wire pclk_rise = pclk_s2_q & ~pclk_s3_q;

    wire wr_ctrl = i_wr && (i_addr == `PML_OFS_CTRL);
    wire wr_status = i_wr && (i_addr == `PML_OFS_STATUS);

    wire [LANES-1:0] done_rise;
    wire [LANES-1:0] done_sticky;
    wire [LANES-1:0] rxvalid_cap;
    wire [LANES-1:0] rxidle_cap;
    wire [LANES-1:0] deemph_cap;
    wire [8*LANES-1:0] rxsym_cap;
    wire [2*LANES-1:0] rxctl_cap;
    wire [3*LANES-1:0] rxstat_cap;

    wire in_training = (state_q >= `PML_ST_POLL_ACTIVE) && (state_q <= `PML_ST_CFG_LN_WAIT);

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
        end else begin
            pclk_s1_q <= i_pclk;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
        end
    end

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwr_q <= `PML_PWR_RESET;
            detect_q <= 1'b0;
            compl_q <= 1'b0;
            swing_q <= `PML_SWING_FULL;
            rate_q <= `PML_RATE_GEN1;
            margin_q <= `PML_MARGIN_NORMAL;
            txidle_q <= 1'b1;
            width16_q <= 1'b0;
            lsel_q <= 3'h0;
            invert_q <= {LANES{1'b0}};
            txsym_q <= 8'h00;
            txctl_q <= 1'b0;
            state_q <= `PML_ST_DET_QUIET;
        end else begin
            // Detect request drops when any lane reports completion; a new write wins
            if (wr_ctrl && i_wdata[`PML_CTRL_DETECT]) begin
                detect_q <= 1'b1;
            end else if (|done_rise) begin
                detect_q <= 1'b0;
            end else if (wr_ctrl) begin
                detect_q <= 1'b0;
            end
            if (wr_ctrl) begin
                pwr_q <= i_wdata[`PML_CTRL_PWR_LSB +: 2];
                compl_q <= i_wdata[`PML_CTRL_COMPL];
                swing_q <= i_wdata[`PML_CTRL_SWING];
                // Reserved rate codes are refused so the PHY never sees them
                if (!i_wdata[`PML_CTRL_RATE_LSB+1]) begin
                    rate_q <= i_wdata[`PML_CTRL_RATE_LSB +: 2];
                end
                // Reserved margin codes 010 and 011 are refused
                if (i_wdata[`PML_CTRL_MARGIN_LSB +: 3] != 3'h2 &&
                    i_wdata[`PML_CTRL_MARGIN_LSB +: 3] != 3'h3) begin
                    margin_q <= i_wdata[`PML_CTRL_MARGIN_LSB +: 3];
                end
                txidle_q <= i_wdata[`PML_CTRL_TXIDLE];
                width16_q <= i_wdata[`PML_CTRL_WIDTH16];
                lsel_q <= i_wdata[`PML_CTRL_LSEL_LSB +: 3];
            end
            if (i_wr && (i_addr == `PML_OFS_INVERT)) begin
                invert_q <= i_wdata[LANES-1:0];
            end
            if (i_wr && (i_addr == `PML_OFS_TXDATA)) begin
                txsym_q <= i_wdata[7:0];
                txctl_q <= i_wdata[`PML_TXD_CTRL_BIT];
            end
            if (i_wr && (i_addr == `PML_OFS_STATE)) begin
                state_q <= i_wdata[4:0];
            end
        end
    end

    // Inference choice follows the training state; unlisted states need none
    always @* begin
        case (state_q)
            `PML_ST_L0: infer_d = `PML_INFER_COMSKP;
            `PML_ST_REC_RCVCFG: infer_d = `PML_INFER_TS;
            `PML_ST_LPBK_ENTRY: infer_d = `PML_INFER_TS;
            `PML_ST_REC_RCVLOCK: infer_d = `PML_INFER_EXIT_UI;
            `PML_ST_SPEED_REC: begin
                // The 128 us window form applies at first generation only
                infer_d = (rate_q == `PML_RATE_GEN1) ?
                          `PML_INFER_EXIT_WIN : `PML_INFER_EXIT_UI;
            end
            default: infer_d = `PML_INFER_NONE;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            reg [7:0] sym_s1_q;
            reg [7:0] sym_s2_q;
            reg [1:0] ctl_s1_q;
            reg [1:0] ctl_s2_q;
            reg [2:0] st_s1_q;
            reg [2:0] st_s2_q;
            reg [2:0] lvl_s1_q;
            reg [2:0] lvl_s2_q;
            reg done_s3_q;
            reg sticky_q;
            reg [7:0] sym_q;
            reg [1:0] ctl_q;
            reg [2:0] st_q;
            reg valid_q;
            reg idle_q;
            reg deemph_q;
            wire deemph_learn = in_training && lvl_s2_q[0] && (ctl_s2_q == 2'h0);

            // Lane inputs cross into the core clock before any use
            always @(posedge i_core_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sym_s1_q <= 8'h00;
                    sym_s2_q <= 8'h00;
                    ctl_s1_q <= 2'h0;
                    ctl_s2_q <= 2'h0;
                    st_s1_q <= 3'h0;
                    st_s2_q <= 3'h0;
                    lvl_s1_q <= 3'h0;
                    lvl_s2_q <= 3'h0;
                    done_s3_q <= 1'b0;
                end else begin
                    sym_s1_q <= i_lane_rx_symbol[8*g +: 8];
                    sym_s2_q <= sym_s1_q;
                    ctl_s1_q <= i_lane_rx_ctrl_flag[2*g +: 2];
                    ctl_s2_q <= ctl_s1_q;
                    st_s1_q <= i_lane_rx_status_code[3*g +: 3];
                    st_s2_q <= st_s1_q;
                    lvl_s1_q <= {i_lane_phy_done[g], i_lane_rx_idle_ind[g],
                                 i_lane_rx_locked_valid[g]};
                    lvl_s2_q <= lvl_s1_q;
                    done_s3_q <= lvl_s2_q[2];
                end
            end
            assign done_rise[g] = lvl_s2_q[2] & ~done_s3_q;

            always @(posedge i_core_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    sticky_q <= 1'b0;
                    sym_q <= 8'h00;
                    ctl_q <= 2'h0;
                    st_q <= 3'h0;
                    valid_q <= 1'b0;
                    idle_q <= 1'b0;
                    deemph_q <= 1'b0;
                end else begin
                    // A completion landing with the clear still counts
                    if (done_rise[g]) begin
                        sticky_q <= 1'b1;
                    end else if (wr_status && i_wdata[g]) begin
                        sticky_q <= 1'b0;
                    end
                    if (pclk_rise) begin
                        sym_q <= sym_s2_q;
                        ctl_q <= ctl_s2_q;
                        st_q <= st_s2_q;
                        valid_q <= lvl_s2_q[0];
                        idle_q <= lvl_s2_q[1];
                        // Partner advertisement only counts on locked data symbols
                        if (deemph_learn) begin
                            deemph_q <= sym_s2_q[`PML_DEEMPH_BIT];
                        end
                    end
                end
            end
            assign done_sticky[g] = sticky_q;
            assign rxsym_cap[8*g +: 8] = sym_q;
            assign rxctl_cap[2*g +: 2] = ctl_q;
            assign rxstat_cap[3*g +: 3] = st_q;
            assign rxvalid_cap[g] = valid_q;
            assign rxidle_cap[g] = idle_q;
            assign deemph_cap[g] = deemph_q;

            // Transmit side changes only at an interface clock rise
            always @(posedge i_core_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_lane_tx_symbol[8*g +: 8] <= 8'h00;
                    o_lane_tx_ctrl_flag[g] <= 1'b0;
                    o_lane_rcvr_detect_req[g] <= 1'b0;
                    o_lane_tx_idle_req[g] <= 1'b1;
                    o_lane_neg_disparity_force[g] <= 1'b0;
                    o_lane_rx_invert[g] <= 1'b0;
                    o_lane_power_state_req[2*g +: 2] <= `PML_PWR_RESET;
                    o_lane_deemphasis_sel[g] <= 1'b0;
                    o_lane_idle_infer_sel[3*g +: 3] <= `PML_INFER_NONE;
                    o_lane_swing_sel[g] <= `PML_SWING_FULL;
                    o_lane_tx_margin_code[3*g +: 3] <= `PML_MARGIN_NORMAL;
                end else if (pclk_rise) begin
                    o_lane_tx_symbol[8*g +: 8] <= txsym_q;
                    o_lane_tx_ctrl_flag[g] <= txctl_q;
                    o_lane_rcvr_detect_req[g] <= detect_q;
                    o_lane_tx_idle_req[g] <= txidle_q;
                    o_lane_neg_disparity_force[g] <= compl_q;
                    o_lane_rx_invert[g] <= invert_q[g];
                    o_lane_power_state_req[2*g +: 2] <= pwr_q;
                    // Learned value goes out in the same strobe, so it never trails the state
                    o_lane_deemphasis_sel[g] <= deemph_learn ? sym_s2_q[`PML_DEEMPH_BIT] : deemph_q;
                    o_lane_idle_infer_sel[3*g +: 3] <= infer_d;
                    o_lane_swing_sel[g] <= swing_q;
                    o_lane_tx_margin_code[3*g +: 3] <= margin_q;
                end
            end
        end
    endgenerate

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_link_train_state_code <= `PML_ST_DET_QUIET;
            o_lane_rate_code <= `PML_RATE_GEN1;
            o_pipe_width16 <= 1'b0;
        end else begin
            o_link_train_state_code <= state_q;
            o_lane_rate_code <= rate_q;
            o_pipe_width16 <= width16_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h00000000;
        end else if (!i_rd) begin
            o_rdata <= 32'h00000000;
        end else begin
            case (i_addr)
                `PML_OFS_CTRL: o_rdata <= {17'h00000, lsel_q, width16_q, txidle_q,
                                           margin_q, rate_q, swing_q, compl_q,
                                           detect_q, pwr_q};
                `PML_OFS_INVERT: o_rdata <= {{(32-LANES){1'b0}}, invert_q};
                `PML_OFS_TXDATA: o_rdata <= {23'h000000, txctl_q, txsym_q};
                `PML_OFS_STATUS: o_rdata <= {{(32-3*LANES){1'b0}}, deemph_cap,
                                             rxvalid_cap, done_sticky};
                `PML_OFS_STATE: o_rdata <= {27'h0000000, state_q};
                `PML_OFS_RXVIEW: o_rdata <= {16'h0000, rxidle_cap[lsel_q],
                                             rxvalid_cap[lsel_q],
                                             rxstat_cap[3*lsel_q +: 3],
                                             1'b0, rxctl_cap[2*lsel_q +: 2],
                                             rxsym_cap[8*lsel_q +: 8]};
                default: o_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule // pml_pipe_mac
`default_nettype wire

// >>> pkg/pml_defs.vh
`ifndef PML_DEFS_VH
`define PML_DEFS_VH

`define PML_LANES 8
`define PML_ADDR_W 8

`define PML_OFS_CTRL 8'h00
`define PML_OFS_INVERT 8'h04
`define PML_OFS_TXDATA 8'h08
`define PML_OFS_STATUS 8'h0C
`define PML_OFS_STATE 8'h10
`define PML_OFS_RXVIEW 8'h14

`define PML_CTRL_PWR_LSB 0
`define PML_CTRL_DETECT 2
`define PML_CTRL_COMPL 3
`define PML_CTRL_SWING 4
`define PML_CTRL_RATE_LSB 5
`define PML_CTRL_MARGIN_LSB 7
`define PML_CTRL_TXIDLE 10
`define PML_CTRL_WIDTH16 11
`define PML_CTRL_LSEL_LSB 12

`define PML_TXD_CTRL_BIT 8
`define PML_DEEMPH_BIT 6

`define PML_PWR_RESET 2'h2
`define PML_RATE_GEN1 2'h0
`define PML_RATE_GEN2 2'h1
`define PML_MARGIN_NORMAL 3'h0
`define PML_MARGIN_WIDE 3'h1
`define PML_SWING_FULL 1'h0

`define PML_INFER_NONE 3'h0
`define PML_INFER_COMSKP 3'h4
`define PML_INFER_TS 3'h5
`define PML_INFER_EXIT_UI 3'h6
`define PML_INFER_EXIT_WIN 3'h7

`define PML_ST_DET_QUIET 5'h00
`define PML_ST_DET_ACTIVE 5'h01
`define PML_ST_POLL_ACTIVE 5'h02
`define PML_ST_POLL_COMPL 5'h03
`define PML_ST_POLL_CFG 5'h04
`define PML_ST_POLL_SPEED 5'h05
`define PML_ST_CFG_LW_START 5'h06
`define PML_ST_CFG_LW_ACCEPT 5'h07
`define PML_ST_CFG_LN_ACCEPT 5'h08
`define PML_ST_CFG_LN_WAIT 5'h09
`define PML_ST_REC_RCVLOCK 5'h0C
`define PML_ST_REC_RCVCFG 5'h0E
`define PML_ST_L0 5'h0F
`define PML_ST_DISABLED 5'h10
`define PML_ST_LPBK_ENTRY 5'h11
`define PML_ST_LPBK_EXIT 5'h12
`define PML_ST_L0S 5'h15
`define PML_ST_L2_WAKE 5'h19
`define PML_ST_SPEED_REC 5'h1A

`endif

// >>> testbench/pml_pipe_mac_monitor.sv
`default_nettype none
module pml_pipe_mac_monitor #(
    parameter int LANES = 8
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_pclk,
    input wire logic [LANES-1:0] i_lane_phy_done,
    input wire logic [31:0] o_rdata,
    input wire logic [8*LANES-1:0] o_lane_tx_symbol,
    input wire logic [LANES-1:0] o_lane_tx_ctrl_flag,
    input wire logic [LANES-1:0] o_lane_rcvr_detect_req,
    input wire logic [LANES-1:0] o_lane_tx_idle_req,
    input wire logic [2*LANES-1:0] o_lane_power_state_req,
    input wire logic [LANES-1:0] o_lane_deemphasis_sel,
    input wire logic [3*LANES-1:0] o_lane_idle_infer_sel,
    input wire logic [3*LANES-1:0] o_lane_tx_margin_code,
    input wire logic [4:0] o_link_train_state_code,
    input wire logic [1:0] o_lane_rate_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    logic pclk_q;
    logic pclk_qq;
    logic [3:0] since_q;
    // Core cycles since the interface clock rose, saturating so it never wraps
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pclk_q <= 1'b0;
            pclk_qq <= 1'b0;
            since_q <= 4'hF;
        end else begin
            pclk_q <= i_pclk;
            pclk_qq <= pclk_q;
            since_q <= (pclk_q && !pclk_qq) ? 4'h0 : (since_q == 4'hF) ? since_q : since_q + 4'h1;
        end
    end
    function automatic logic [2:0] infer_of(input logic [4:0] st, input logic [1:0] rt);
        case (st)
            5'h0F: infer_of = 3'h4;
            5'h0E, 5'h11: infer_of = 3'h5;
            5'h0C: infer_of = 3'h6;
            5'h1A: infer_of = (rt == 2'h0) ? 3'h7 : 3'h6;
            default: infer_of = 3'h0;
        endcase
    endfunction
    sequence done_rise_s;
        $rose(i_lane_phy_done[0]) && o_lane_rcvr_detect_req[0];
    endsequence
    sequence detect_drop_s;
        ##[1:24] !o_lane_rcvr_detect_req[0];
    endsequence
    tx_broadcast_a: assert property (
        o_lane_tx_symbol == {LANES{o_lane_tx_symbol[7:0]}}
        && (&o_lane_tx_ctrl_flag || !(|o_lane_tx_ctrl_flag))) else $error("lanes differ");
    lane_launch_a: assert property (
        $changed({o_lane_tx_symbol, o_lane_tx_idle_req, o_lane_rcvr_detect_req,
        o_lane_power_state_req, o_lane_tx_margin_code}) |-> since_q <= 4'h5)
        else $error("lane output moved between clock rises");
    reset_vals_a: assert property ($rose(i_resetn) |-> o_rdata == 32'h0
        && o_lane_tx_idle_req == {LANES{1'b1}} && o_lane_power_state_req == {LANES{2'h2}})
        else $error("bad values after reset");
    rate_legal_a: assert property (!o_lane_rate_code[1]) else $error("reserved rate");
    margin_legal_a: assert property (o_lane_tx_margin_code[2:1] != 2'h1)
        else $error("reserved margin");
    infer_map_a: assert property ($changed(o_lane_idle_infer_sel[2:0]) |->
        o_lane_idle_infer_sel[2:0] == infer_of(o_link_train_state_code, o_lane_rate_code))
        else $error("idle inference mismatch");
    deemph_state_a: assert property ($changed(o_lane_deemphasis_sel[0]) |->
        o_link_train_state_code inside {[5'h02:5'h09]}) else $error("de-emphasis outside training");
    detect_clear_a: assert property (done_rise_s |-> detect_drop_s)
        else $error("detect request not dropped");
endmodule // pml_pipe_mac_monitor
bind pml_pipe_mac pml_pipe_mac_monitor #(.LANES(LANES)) u_monitor (.i_core_clk, .i_resetn,
    .i_pclk, .i_lane_phy_done, .o_rdata, .o_lane_tx_symbol, .o_lane_tx_ctrl_flag,
    .o_lane_rcvr_detect_req, .o_lane_tx_idle_req, .o_lane_power_state_req,
    .o_lane_deemphasis_sel, .o_lane_idle_infer_sel, .o_lane_tx_margin_code,
    .o_link_train_state_code, .o_lane_rate_code);
`default_nettype wire

// >>> testbench/pml_phy_model.sv
`default_nettype none
module pml_phy_model (
    input wire logic [7:0] i_detect,
    input wire logic [15:0] i_power,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_valid,
    output logic o_pclk,
    output logic [63:0] o_rx_symbol,
    output logic [15:0] o_rx_ctrl,
    output logic [7:0] o_rx_valid,
    output logic [7:0] o_done,
    output logic [23:0] o_status,
    output logic [7:0] o_idle
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] power_q = 16'hAAAA;
    initial {o_pclk, o_rx_symbol, o_rx_ctrl, o_rx_valid, o_done, o_status, o_idle} = '0;
    always #400 o_pclk = ~o_pclk;
    // Invalid symbols toggle so a stale byte is never taken for fresh data
    always @(posedge o_pclk) begin
        power_q <= i_power;
        o_done <= ((|i_detect || i_power != power_q) && !o_done[0]) ? 8'hFF : 8'h00;
        o_status <= (|i_detect) ? {8{3'h3}} : 24'h0;
        o_rx_valid <= {8{i_rx_valid}};
        o_idle <= {8{!i_rx_valid}};
        o_rx_symbol <= i_rx_valid ? {8{i_rx_byte}} : ~o_rx_symbol;
        o_rx_ctrl <= 16'h0;
    end
endmodule // pml_phy_model
`default_nettype wire

// >>> testbench/pml_pipe_mac_tb_top.sv
`include "pml_defs.vh"
`default_nettype none
module pml_pipe_mac_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_valid = 1'b0;
    logic [31:0] rdata;
    logic [63:0] rx_sym, tx_sym;
    logic [23:0] rx_st, isel, mrg;
    logic [15:0] rx_ctl, pwr;
    logic [7:0] rx_val, done, rx_idle, tx_ctl, det, txi, cmp, inv, dmp, swg;
    logic [4:0] st;
    logic [1:0] rate;
    logic pclk, w16;
    int errors = 0;
    int check_count = 0;
    logic [4:0] codes [19] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h09, 5'h0C, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h15, 5'h19, 5'h1A};
    always #50 i_core_clk = ~i_core_clk;
    pml_phy_model u_phy (.i_detect(det), .i_power(pwr), .i_rx_byte(rx_byte), .i_rx_valid(rx_valid),
        .o_pclk(pclk), .o_rx_symbol(rx_sym), .o_rx_ctrl(rx_ctl), .o_rx_valid(rx_val),
        .o_done(done), .o_status(rx_st), .o_idle(rx_idle));
    pml_pipe_mac uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_pclk(pclk),
        .i_lane_rx_symbol(rx_sym), .i_lane_rx_ctrl_flag(rx_ctl), .i_lane_rx_locked_valid(rx_val),
        .i_lane_phy_done(done), .i_lane_rx_status_code(rx_st), .i_lane_rx_idle_ind(rx_idle),
        .o_lane_tx_symbol(tx_sym), .o_lane_tx_ctrl_flag(tx_ctl), .o_lane_rcvr_detect_req(det),
        .o_lane_tx_idle_req(txi), .o_lane_neg_disparity_force(cmp), .o_lane_rx_invert(inv),
        .o_lane_power_state_req(pwr), .o_lane_deemphasis_sel(dmp), .o_lane_idle_infer_sel(isel),
        .o_lane_swing_sel(swg), .o_lane_tx_margin_code(mrg), .o_link_train_state_code(st),
        .o_lane_rate_code(rate), .o_pipe_width16(w16));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(negedge i_core_clk);
        chk({32'h0, rdata}, {32'h0, exp});
    endtask
    // Lane outputs only move after a rise, so wait for one and let it settle
    task automatic lane_wait;
        int n;
        n = 0;
        while (pclk === 1'b1 && n < 20) begin
            @(posedge i_core_clk);
            n++;
        end
        while (pclk !== 1'b1 && n < 40) begin
            @(posedge i_core_clk);
            n++;
        end
        if (pclk !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: interface clock stuck", $time);
            give_verdict;
        end
        repeat (6) @(posedge i_core_clk);
    endtask
    function automatic logic [2:0] sel_for(input logic [4:0] c);
        case (c)
            5'h0F: sel_for = 3'h4;
            5'h0E, 5'h11: sel_for = 3'h5;
            5'h0C, 5'h1A: sel_for = 3'h6;
            default: sel_for = 3'h0;
        endcase
    endfunction
    initial begin
        int p;
        repeat (3) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        rd_chk(`PML_OFS_CTRL, 32'h0000_0402);
        rd_chk(8'h20, 32'h0);
        lane_wait;
        chk({txi, pwr}, 24'hFF_AAAA);
        wr(`PML_OFS_TXDATA, 32'h1BC);
        lane_wait;
        chk(tx_sym, {8{8'hBC}});
        chk(tx_ctl, 8'hFF);
        wr(`PML_OFS_TXDATA, 32'h055);
        wr(`PML_OFS_INVERT, 32'hA5);
        lane_wait;
        chk(tx_sym, {8{8'h55}});
        chk({tx_ctl, inv}, 16'h00A5);
        for (p = 0; p < 4; p++) begin
            wr(`PML_OFS_CTRL, 32'hB8 | p | ((p & 1) << 10));
            lane_wait;
            chk({pwr, txi, cmp, swg, rate}, {{8{p[1:0]}}, {8{p[0]}}, 16'hFFFF, 2'h1});
            chk(mrg, {8{3'h1}});
        end
        wr(`PML_OFS_CTRL, 32'hF8);
        rd_chk(`PML_OFS_CTRL, 32'h0000_00B8);
        wr(`PML_OFS_CTRL, 32'h138);
        lane_wait;
        chk({rate, mrg}, {2'h1, {8{3'h1}}});
        wr(`PML_OFS_CTRL, 32'h3C);
        lane_wait;
        chk({det, mrg}, {8'hFF, 24'h0});
        for (p = 0; p < 60 && det !== 8'h00; p++) @(negedge i_core_clk);
        chk(det, 8'h00);
        rd_chk(`PML_OFS_STATUS, 32'hFF);
        wr(`PML_OFS_STATUS, 32'hFF);
        rd_chk(`PML_OFS_STATUS, 32'h0);
        for (p = 0; p < 19; p++) begin
            wr(`PML_OFS_STATE, {27'h0, codes[p]});
            rd_chk(`PML_OFS_STATE, {27'h0, codes[p]});
            lane_wait;
            chk({st, isel}, {codes[p], {8{sel_for(codes[p])}}});
        end
        wr(`PML_OFS_CTRL, 32'h18);
        lane_wait;
        chk(isel, {8{3'h7}});
        wr(`PML_OFS_STATE, 32'h02);
        rx_byte <= 8'h40;
        rx_valid <= 1'b1;
        lane_wait;
        lane_wait;
        chk(dmp, 8'hFF);
        rd_chk(`PML_OFS_RXVIEW, 32'h4040);
        wr(`PML_OFS_STATE, 32'h0F);
        rx_byte <= 8'h00;
        wr(`PML_OFS_CTRL, 32'h3818);
        lane_wait;
        lane_wait;
        chk({dmp, 7'h0, w16}, 16'hFF01);
        rd_chk(`PML_OFS_RXVIEW, 32'h4000);
        rd_chk(`PML_OFS_STATUS, 32'h00FF_FF00);
        give_verdict;
    end
endmodule // pml_pipe_mac_tb_top
`default_nettype wire
